// ==== verilog/crp_pkg.sv ====
// package: register map, field positions, reset values and timing constants
package crp_pkg;

  // register indices; the bus byte address is four times the index
  localparam logic [7:0] IDX_WATERMARK = 8'hb4;
  localparam logic [7:0] IDX_IDENT = 8'hc0;
  localparam logic [7:0] IDX_GLOBAL = 8'hc6;
  localparam logic [7:0] IDX_CMD = 8'hc8;
  localparam logic [7:0] IDX_DATA_LO = 8'hd0;
  localparam logic [7:0] IDX_DATA_HI = 8'hd2;
  localparam logic [7:0] IDX_POWER = 8'hd4;
  localparam logic [7:0] IDX_TIMING = 8'hd6;

  localparam logic [9:0] ADDR_WATERMARK = {IDX_WATERMARK, 2'h0};
  localparam logic [9:0] ADDR_IDENT = {IDX_IDENT, 2'h0};
  localparam logic [9:0] ADDR_GLOBAL = {IDX_GLOBAL, 2'h0};
  localparam logic [9:0] ADDR_CMD = {IDX_CMD, 2'h0};
  localparam logic [9:0] ADDR_DATA_LO = {IDX_DATA_LO, 2'h0};
  localparam logic [9:0] ADDR_DATA_HI = {IDX_DATA_HI, 2'h0};
  localparam logic [9:0] ADDR_POWER = {IDX_POWER, 2'h0};
  localparam logic [9:0] ADDR_TIMING = {IDX_TIMING, 2'h0};

  // reset values
  localparam logic [11:0] WATERMARK_RESET = 12'h040;
  localparam logic [15:0] GLOBAL_DEFAULT = 16'h0835;
  localparam logic [15:0] TIMING_RESET = 16'h080c;

  // indirect command fields
  localparam int CMD_READ_BIT = 12;
  localparam int CMD_TSEL_LSB = 10;
  localparam logic [1:0] TSEL_STATS = 2'h3;
  localparam logic [15:0] CMD_MASK = 16'h1c1f;
  localparam int NUM_STATS = 32;
  localparam int STAT_WIDTH = 32;

  // power event control fields
  localparam int PWR_DELAY_BIT = 14;
  localparam int PWR_POL_BIT = 12;
  localparam int PWR_EN_LSB = 8;
  localparam int PWR_AUTO_BIT = 7;
  localparam int PWR_TO_NORMAL_BIT = 6;
  localparam int PWR_STAT_LSB = 2;
  localparam logic [15:0] PWR_MASK = 16'h5fc3;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_ENERGY = 2'h1;
  localparam logic [1:0] MODE_SOFT_DOWN = 2'h2;
  localparam logic [1:0] MODE_SAVING = 2'h3;

  // event positions in the wake source bits and enables
  localparam int EV_ENERGY = 0;
  localparam int EV_LINK_UP = 1;
  localparam int EV_MAGIC = 2;
  localparam int EV_FRAME = 3;

  // timing: least times round up to whole cycles
  localparam int CLK_PERIOD_NS = 5;
  localparam int WAKE_UNIT_NS = 16000000;
  localparam int SLEEP_UNIT_NS = 1000000000;
  localparam int WAKE_UNIT_CYC =
    (WAKE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SLEEP_UNIT_CYC =
    (SLEEP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic {ps_full, ps_low} crp_pstate_type;

endpackage

// ==== verilog/crp_stat_bank.sv ====
// statistics counter bank with clear-on-read and registered read port
`timescale 1ns/100ps
module crp_stat_bank #(
  parameter int N = 32,
  parameter int W = 32
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [N-1:0] count_en,
  input wire logic rd_en,
  input wire logic [$clog2(N)-1:0] rd_addr,
  output logic [W-1:0] rd_data_q
);
  logic [W-1:0] cnt_q [N];
  logic [W-1:0] cnt_d [N];
  logic [W-1:0] rd_data_d;
  localparam int AW = $clog2(N);

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_cnt
      // an event in the clearing cycle is kept: the counter restarts at one
      always_comb begin
        if (rd_en && rd_addr == AW'(i)) begin
          cnt_d[i] = {{(W-1){1'b0}}, count_en[i]};
        end else begin
          cnt_d[i] = cnt_q[i] + {{(W-1){1'b0}}, count_en[i]};
        end
      end
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          cnt_q[i] <= '0;
        end else begin
          cnt_q[i] <= cnt_d[i];
        end
      end
    end
  endgenerate

  always_comb begin
    rd_data_d = rd_en ? cnt_q[rd_addr] : rd_data_q;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rd_data_q <= '0;
    end else begin
      rd_data_q <= rd_data_d;
    end
  end
endmodule

// ==== verilog/crp_regs.sv ====
// control, statistics-access and power-event register slice on wishbone
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/100ps
module crp_regs #(
  parameter int WAKE_UNIT_CYC = crp_pkg::WAKE_UNIT_CYC,
  parameter int SLEEP_UNIT_CYC = crp_pkg::SLEEP_UNIT_CYC,
  parameter logic [7:0] FAMILY_CODE = 8'h5a,  // arbitrary value
  parameter logic [3:0] CHIP_CODE = 4'h3,     // arbitrary value
  parameter logic [2:0] REV_CODE = 3'h2       // arbitrary value
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] stat_count_en,
  input wire logic [3:0] wake_events,
  input wire logic energy_present,
  input wire logic clocks_ready,
  output logic [11:0] rx_overrun_level,
  output logic [1:0] power_mode,
  output logic link_active,
  output logic wake_event_output
);
  logic req;
  logic wr;
  logic ack_q;
  logic [31:0] dat_q;
  logic [31:0] dat_d;
  logic [15:0] rd_val;
  logic [11:0] wm_q, wm_d;
  logic [15:0] cmd_q, cmd_d;
  logic [15:0] dlo_q, dlo_d, dhi_q, dhi_d;
  logic [15:0] tim_q, tim_d;
  logic stat_rd_q, stat_rd_d;
  logic cap_q;
  logic [31:0] bank_data;
  logic [15:0] pwr_q, pwr_d;
  logic [3:0] wsrc_q, wsrc_d;
  logic [15:0] cmd_new;
  crp_pkg::crp_pstate_type pst_q, pst_d;
  logic [31:0] div_q, div_d;
  logic [7:0] units_q, units_d;
  logic pme_q, pme_d;
  logic link_q, link_d;
  logic low;
  logic qualify;
  logic unit_done;
  logic expire;
  logic [7:0] target;
  logic [31:0] unit_len;
  logic wake_act;
  logic wake_hold;

  function automatic logic [15:0] lane_merge(input logic [15:0] old,
                                             input logic [15:0] val,
                                             input logic [1:0] sel);
    lane_merge = {sel[1] ? val[15:8] : old[15:8],
                  sel[0] ? val[7:0] : old[7:0]};
  endfunction

  // wishbone slave: one wait state, then ack
  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;

  always_comb begin
    rd_val = 16'h0000;
    if (wb_adr_i == crp_pkg::ADDR_WATERMARK) begin
      rd_val = {4'h0, wm_q};
    end else if (wb_adr_i == crp_pkg::ADDR_IDENT) begin
      rd_val = {FAMILY_CODE, CHIP_CODE, REV_CODE, 1'b0};
    end else if (wb_adr_i == crp_pkg::ADDR_GLOBAL) begin
      rd_val = crp_pkg::GLOBAL_DEFAULT;
    end else if (wb_adr_i == crp_pkg::ADDR_CMD) begin
      rd_val = cmd_q;
    end else if (wb_adr_i == crp_pkg::ADDR_DATA_LO) begin
      rd_val = dlo_q;
    end else if (wb_adr_i == crp_pkg::ADDR_DATA_HI) begin
      rd_val = dhi_q;
    end else if (wb_adr_i == crp_pkg::ADDR_POWER) begin
      rd_val = {pwr_q[15:6], wsrc_q, pwr_q[1:0]};
    end else if (wb_adr_i == crp_pkg::ADDR_TIMING) begin
      rd_val = tim_q;
    end
    // unmapped addresses are acked with zero data
    dat_d = req ? {16'h0000, rd_val} : dat_q;
  end

  // host-written registers and indirect access
  always_comb begin
    wm_d = wm_q;
    tim_d = tim_q;
    dlo_d = dlo_q;
    dhi_d = dhi_q;
    cmd_new = lane_merge(cmd_q, wb_dat_i[15:0], wb_sel_i[1:0]) &
              crp_pkg::CMD_MASK;
    cmd_d = cmd_q;
    stat_rd_d = 1'b0;
    if (wr && wb_adr_i == crp_pkg::ADDR_WATERMARK) begin
      wm_d = 12'(lane_merge({4'h0, wm_q}, wb_dat_i[15:0],
                            wb_sel_i[1:0]));
    end
    if (wr && wb_adr_i == crp_pkg::ADDR_TIMING) begin
      tim_d = lane_merge(tim_q, wb_dat_i[15:0], wb_sel_i[1:0]);
    end
    if (wr && wb_adr_i == crp_pkg::ADDR_CMD) begin
      cmd_d = cmd_new;
      // other table codes are reserved and do nothing
      stat_rd_d = cmd_new[crp_pkg::CMD_READ_BIT] &&
        cmd_new[crp_pkg::CMD_TSEL_LSB +: 2] == crp_pkg::TSEL_STATS;
    end
    if (cap_q) begin
      {dhi_d, dlo_d} = bank_data;
    end else begin
      if (wr && wb_adr_i == crp_pkg::ADDR_DATA_LO) begin
        dlo_d = lane_merge(dlo_q, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
      if (wr && wb_adr_i == crp_pkg::ADDR_DATA_HI) begin
        dhi_d = lane_merge(dhi_q, wb_dat_i[15:0], wb_sel_i[1:0]);
      end
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
      wm_q <= crp_pkg::WATERMARK_RESET;
      tim_q <= crp_pkg::TIMING_RESET;
      cmd_q <= 16'h0000;
      dlo_q <= 16'h0000;
      dhi_q <= 16'h0000;
      stat_rd_q <= 1'b0;
      cap_q <= 1'b0;
    end else begin
      ack_q <= req;
      dat_q <= dat_d;
      wm_q <= wm_d;
      tim_q <= tim_d;
      cmd_q <= cmd_d;
      dlo_q <= dlo_d;
      dhi_q <= dhi_d;
      stat_rd_q <= stat_rd_d;
      cap_q <= stat_rd_q;
    end
  end

  crp_stat_bank #(
    .N(crp_pkg::NUM_STATS),
    .W(crp_pkg::STAT_WIDTH)
  ) u_bank (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .count_en(stat_count_en),
    .rd_en(stat_rd_q),
    .rd_addr(cmd_q[4:0]),
    .rd_data_q(bank_data)
  );

  // power events and energy-detect state
  assign low = (pst_q == crp_pkg::ps_low);
  assign unit_len = low ? WAKE_UNIT_CYC : SLEEP_UNIT_CYC;
  // a zero unit count is not allowed; treat it as one so the timer ends
  assign target = ((low ? tim_q[15:8] : tim_q[7:0]) == 8'h00) ? 8'h01 :
                  (low ? tim_q[15:8] : tim_q[7:0]);
  assign qualify = (pwr_q[1:0] == crp_pkg::MODE_ENERGY) &&
                   (low ? energy_present : !energy_present);
  assign unit_done = qualify && (div_q == unit_len - 32'h1);
  assign expire = unit_done &&
                  ({1'b0, units_q} + 9'h1 >= {1'b0, target});
  assign wake_act = |(wsrc_q & pwr_q[crp_pkg::PWR_EN_LSB +: 4]);
  assign wake_hold = pwr_q[crp_pkg::PWR_DELAY_BIT] &&
                     pwr_q[crp_pkg::PWR_AUTO_BIT] && !clocks_ready;

  always_comb begin
    pwr_d = pwr_q;
    wsrc_d = wsrc_q;
    pst_d = pst_q;
    div_d = div_q + 32'h1;
    units_d = units_q;
    if (wr && wb_adr_i == crp_pkg::ADDR_POWER) begin
      pwr_d = lane_merge(pwr_q, wb_dat_i[15:0], wb_sel_i[1:0]) &
              crp_pkg::PWR_MASK;
      if (wb_sel_i[0]) begin
        wsrc_d = wsrc_q & ~wb_dat_i[crp_pkg::PWR_STAT_LSB +: 4];
      end
    end
    wsrc_d = wsrc_d | wake_events;
    if (!qualify) begin
      div_d = 32'h0;
      units_d = 8'h0;
    end else if (unit_done) begin
      div_d = 32'h0;
      units_d = units_q + 8'h1;
    end
    if (expire) begin
      div_d = 32'h0;
      units_d = 8'h0;
      if (!low) begin
        pst_d = crp_pkg::ps_low;
      end else if (pwr_q[crp_pkg::PWR_AUTO_BIT]) begin
        pst_d = crp_pkg::ps_full;
        if (pwr_q[crp_pkg::PWR_TO_NORMAL_BIT]) begin
          pwr_d[1:0] = crp_pkg::MODE_NORMAL;
        end
      end
    end
    // low/full power state exists only in energy detect mode
    if (pwr_d[1:0] != crp_pkg::MODE_ENERGY) begin
      pst_d = crp_pkg::ps_full;
    end
    pme_d = pwr_q[crp_pkg::PWR_POL_BIT] ? (wake_act && !wake_hold) :
            !(wake_act && !wake_hold);
    link_d = (pwr_d[1:0] == crp_pkg::MODE_NORMAL) ||
             (pwr_d[1:0] == crp_pkg::MODE_ENERGY &&
              pst_d == crp_pkg::ps_full);
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_q <= 16'h0000;
      wsrc_q <= 4'h0;
      pst_q <= crp_pkg::ps_full;
      div_q <= 32'h0;
      units_q <= 8'h0;
      pme_q <= 1'b1;
      link_q <= 1'b1;
    end else begin
      pwr_q <= pwr_d;
      wsrc_q <= wsrc_d;
      pst_q <= pst_d;
      div_q <= div_d;
      units_q <= units_d;
      pme_q <= pme_d;
      link_q <= link_d;
    end
  end

  assign rx_overrun_level = wm_q;
  assign power_mode = pwr_q[1:0];
  assign link_active = link_q;
  assign wake_event_output = pme_q;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  chk_watermark_write: assert property (
    wr && wb_adr_i == crp_pkg::ADDR_WATERMARK && wb_sel_i[1:0] == 2'h3
    |=> wm_q == $past(wb_dat_i[11:0]))
    else $error("watermark write not stored");

  chk_ident_read: assert property (
    wb_ack_o && wb_adr_i == crp_pkg::ADDR_IDENT
    |-> wb_dat_o[15:1] == {FAMILY_CODE, CHIP_CODE, REV_CODE})
    else $error("identity word wrong");

  chk_cmd_launch: assert property (
    wr && wb_adr_i == crp_pkg::ADDR_CMD && wb_sel_i[1:0] == 2'h3 &&
    wb_dat_i[12] && wb_dat_i[11:10] == 2'h3
    |=> stat_rd_q && cmd_q[4:0] == $past(wb_dat_i[4:0]) ##1 cap_q)
    else $error("counter read not launched");

  chk_cmd_noop: assert property (
    wr && wb_adr_i == crp_pkg::ADDR_CMD && wb_sel_i[1] && !wb_dat_i[12]
    |=> !stat_rd_q ##1 !cap_q)
    else $error("read launched without read enable");

  chk_data_capture: assert property (
    cap_q |=> {dhi_q, dlo_q} == $past(bank_data))
    else $error("indirect data not captured");

  chk_data_hold: assert property (
    !cap_q && !(wr && (wb_adr_i == crp_pkg::ADDR_DATA_LO ||
                       wb_adr_i == crp_pkg::ADDR_DATA_HI))
    |=> $stable({dhi_q, dlo_q}))
    else $error("indirect data changed without cause");

  chk_wake_gate: assert property (
    !wake_act |=> wake_event_output == !$past(pwr_q[crp_pkg::PWR_POL_BIT]))
    else $error("wake output active with no enabled source");

  chk_wake_delay: assert property (
    wake_act && wake_hold
    |=> wake_event_output == !$past(pwr_q[crp_pkg::PWR_POL_BIT]))
    else $error("wake output not held off");

  chk_wake_nodelay: assert property (
    wake_act && !pwr_q[crp_pkg::PWR_AUTO_BIT]
    |=> wake_event_output == $past(pwr_q[crp_pkg::PWR_POL_BIT]))
    else $error("wake output delayed without auto wake");

  chk_source_set: assert property (
    wake_events[crp_pkg::EV_ENERGY] |=> wsrc_q[crp_pkg::EV_ENERGY])
    else $error("wake source not recorded");

  chk_stay_low: assert property (
    low && !pwr_q[crp_pkg::PWR_AUTO_BIT] &&
    !(wr && wb_adr_i == crp_pkg::ADDR_POWER) |=> low)
    else $error("left low power without auto wake");

  cov_counter_read: cover property (stat_rd_q ##2 cap_q == 1'b0);
  cov_auto_wake: cover property (low ##1 !low);
  cov_wake_pin: cover property (wake_act && !wake_hold ##1 1'b1);
endmodule

// ==== test/crp_host_model.sv ====
// wishbone classic host model issuing one register cycle at a time
`timescale 1ns/100ps
module crp_host_model (
  input wire logic mclk,
  output logic cyc,
  output logic stb,
  output logic we,
  output logic [9:0] adr,
  output logic [3:0] sel,
  output logic [31:0] dat,
  input wire logic [31:0] rdat,
  input wire logic ack
);
  initial begin
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 10'h0;
    sel = 4'h0;
    dat = 32'h0;
  end

  // request held until ack is seen at an edge; idle data is inverted so
  // the slave never sees a stale copy of the last write
  task automatic cycle(input logic w, input logic [9:0] a,
                       input logic [15:0] d, output logic [15:0] q);
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= 4'h3;
    dat <= {16'h0, d};
    @(posedge mclk);
    while (ack !== 1'b1) @(posedge mclk);
    q = rdat[15:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    dat <= ~{16'h0, d};
  endtask
endmodule

// ==== test/tb_ctrl_counter_power_regs.sv ====
// self-checking bench for the control, counter and power register slice
`timescale 1ns/100ps
module tb_ctrl_counter_power_regs;
  localparam logic [15:0] ID_WORD = {8'h5a, 4'h3, 3'h2, 1'b0};
  logic mclk, sys_rst, cyc, stb, we, ack, energy_present, clocks_ready;
  logic link_active, wake_event_output;
  logic [9:0] adr;
  logic [3:0] sel, wake_events;
  logic [31:0] wdat, rdat, stat_count_en;
  logic [11:0] rx_overrun_level;
  logic [1:0] power_mode;
  int failures = 0;
  int compares = 0;
  int cycles = 0;

  crp_regs #(.WAKE_UNIT_CYC(4), .SLEEP_UNIT_CYC(8), .FAMILY_CODE(8'h5a),
    .CHIP_CODE(4'h3), .REV_CODE(3'h2)) dut (.mclk(mclk), .sys_rst(sys_rst),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .stat_count_en(stat_count_en), .wake_events(wake_events),
    .energy_present(energy_present), .clocks_ready(clocks_ready),
    .rx_overrun_level(rx_overrun_level), .power_mode(power_mode),
    .link_active(link_active), .wake_event_output(wake_event_output));

  crp_host_model host (.mclk(mclk), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat(wdat), .rdat(rdat), .ack(ack));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // the long counter run dominates; the ceiling leaves ample margin
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      failures++;
      wrap_up();
    end
  end

  task automatic wrap_up;
    if (failures == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(logic [9:0] a, logic [15:0] d);
    logic [15:0] q;
    host.cycle(1'b1, a, d, q);
  endtask

  task automatic rchk(string n, logic [9:0] a, logic [15:0] e);
    logic [15:0] q;
    host.cycle(1'b0, a, 16'h0, q);
    chk(n, e, q);
  endtask

  task automatic ticks(int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic wait_link(logic want);
    int i;
    i = 0;
    while (link_active !== want && i < 60) begin
      @(negedge mclk);
      i++;
    end
  endtask

  task automatic pulse_event(logic [3:0] ev);
    @(posedge mclk);
    wake_events <= ev;
    @(posedge mclk);
    wake_events <= 4'h0;
    ticks(3);
  endtask

  task automatic set_energy(logic v);
    @(posedge mclk);
    energy_present <= v;
  endtask

  task automatic t_reset;
    chk("level", 16'h0040, {4'h0, rx_overrun_level});
    chk("mode", 16'h0, {14'h0, power_mode});
    chk("link", 16'h1, {15'h0, link_active});
    chk("pin", 16'h1, {15'h0, wake_event_output});
    rchk("watermark", crp_pkg::ADDR_WATERMARK, 16'h0040);
    rchk("data low", crp_pkg::ADDR_DATA_LO, 16'h0);
    rchk("data high", crp_pkg::ADDR_DATA_HI, 16'h0);
    rchk("identity", crp_pkg::ADDR_IDENT, ID_WORD);
    rchk("global", crp_pkg::ADDR_GLOBAL, 16'h0835);
    rchk("timing", crp_pkg::ADDR_TIMING, 16'h080c);
    rchk("power", crp_pkg::ADDR_POWER, 16'h0);
  endtask

  task automatic t_writes;
    wr(crp_pkg::ADDR_WATERMARK, 16'hffff);
    rchk("watermark", crp_pkg::ADDR_WATERMARK, 16'h0fff);
    wr(crp_pkg::ADDR_WATERMARK, 16'h0123);
    chk("level", 16'h0123, {4'h0, rx_overrun_level});
    wr(crp_pkg::ADDR_IDENT, 16'hffff);
    rchk("identity", crp_pkg::ADDR_IDENT, ID_WORD);
    wr(crp_pkg::ADDR_GLOBAL, 16'h0);
    rchk("global", crp_pkg::ADDR_GLOBAL, 16'h0835);
    wr(10'h3fc, 16'hffff);
    rchk("unmapped", 10'h3fc, 16'h0);
  endtask

  task automatic t_counters;
    @(posedge mclk);
    stat_count_en <= 32'h20;
    repeat (3) @(posedge mclk);
    stat_count_en <= 32'h0;
    // table select 11 is the only legal host choice
    wr(crp_pkg::ADDR_CMD, 16'h1c05);
    rchk("count low", crp_pkg::ADDR_DATA_LO, 16'h3);
    rchk("count high", crp_pkg::ADDR_DATA_HI, 16'h0);
    wr(crp_pkg::ADDR_CMD, 16'h0c05);
    rchk("held low", crp_pkg::ADDR_DATA_LO, 16'h3);
    wr(crp_pkg::ADDR_CMD, 16'h1c05);
    rchk("cleared", crp_pkg::ADDR_DATA_LO, 16'h0);
    @(posedge mclk);
    stat_count_en <= 32'h8000_0000;
    repeat (65537) @(posedge mclk);
    stat_count_en <= 32'h0;
    wr(crp_pkg::ADDR_CMD, 16'h1c1f);
    rchk("wide low", crp_pkg::ADDR_DATA_LO, 16'h1);
    rchk("wide high", crp_pkg::ADDR_DATA_HI, 16'h1);
  endtask

  task automatic t_wake;
    wr(crp_pkg::ADDR_POWER, 16'h1400);
    pulse_event(4'h4);
    chk("pin", 16'h1, {15'h0, wake_event_output});
    rchk("source", crp_pkg::ADDR_POWER, 16'h1410);
    wr(crp_pkg::ADDR_POWER, 16'h1410);
    ticks(1);
    chk("pin", 16'h0, {15'h0, wake_event_output});
    wr(crp_pkg::ADDR_POWER, 16'h1000);
    pulse_event(4'h8);
    chk("pin", 16'h0, {15'h0, wake_event_output});
    rchk("source", crp_pkg::ADDR_POWER, 16'h1020);
    wr(crp_pkg::ADDR_POWER, 16'h1020);
    @(posedge mclk);
    clocks_ready <= 1'b0;
    wr(crp_pkg::ADDR_POWER, 16'h5480);
    pulse_event(4'h4);
    chk("pin", 16'h0, {15'h0, wake_event_output});
    @(posedge mclk);
    clocks_ready <= 1'b1;
    ticks(3);
    chk("pin", 16'h1, {15'h0, wake_event_output});
    wr(crp_pkg::ADDR_POWER, 16'h5490);
    @(posedge mclk);
    clocks_ready <= 1'b0;
    wr(crp_pkg::ADDR_POWER, 16'h5400);
    pulse_event(4'h4);
    chk("pin", 16'h1, {15'h0, wake_event_output});
    wr(crp_pkg::ADDR_POWER, 16'h0410);
    clocks_ready <= 1'b1;
    pulse_event(4'h4);
    chk("pin", 16'h0, {15'h0, wake_event_output});
    wr(crp_pkg::ADDR_POWER, 16'h0010);
    ticks(1);
    chk("pin", 16'h1, {15'h0, wake_event_output});
  endtask

  task automatic t_energy;
    for (int m = 0; m < 4; m++) begin
      wr(crp_pkg::ADDR_POWER, 16'(m));
      rchk("power", crp_pkg::ADDR_POWER, 16'(m));
      chk("mode", 16'(m), {14'h0, power_mode});
      chk("link", {15'h0, m < 2}, {15'h0, link_active});
    end
    wr(crp_pkg::ADDR_TIMING, 16'h0101);
    wr(crp_pkg::ADDR_POWER, 16'h00c1);
    set_energy(1'b0);
    wait_link(1'b0);
    chk("asleep", 16'h0, {15'h0, link_active});
    set_energy(1'b1);
    wait_link(1'b1);
    chk("awake", 16'h1, {15'h0, link_active});
    chk("mode", 16'h0, {14'h0, power_mode});
    wr(crp_pkg::ADDR_POWER, 16'h0081);
    set_energy(1'b0);
    wait_link(1'b0);
    set_energy(1'b1);
    wait_link(1'b1);
    chk("awake", 16'h1, {15'h0, link_active});
    chk("mode", 16'h1, {14'h0, power_mode});
    wr(crp_pkg::ADDR_POWER, 16'h0001);
    set_energy(1'b0);
    wait_link(1'b0);
    set_energy(1'b1);
    ticks(40);
    chk("no wake", 16'h0, {15'h0, link_active});
    wr(crp_pkg::ADDR_POWER, 16'h0);
    ticks(2);
    chk("normal", 16'h1, {15'h0, link_active});
  endtask

  initial begin
    sys_rst = 1'b1;
    stat_count_en = 32'h0;
    wake_events = 4'h0;
    energy_present = 1'b1;
    clocks_ready = 1'b1;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    @(negedge mclk);
    t_reset();
    t_writes();
    t_counters();
    t_wake();
    t_energy();
    wrap_up();
  end
endmodule
